// ==== shared/ccpc_defines.svh ====
// Purpose: Named constants of the clock output and power control block
// Assumes: Core clock is the 10 MHz reference input
// Notes:   Definitions only
`ifndef CCPC_DEFINES_SVH
`define CCPC_DEFINES_SVH

// ============================================================
// Configuration bytes
`define CCPC_CFG_BYTES      12
`define CCPC_PTR_W          8
`define CCPC_B_OE           8'h00
`define CCPC_B_SLEW         8'h01
`define CCPC_B_AMP          8'h02
`define CCPC_B_REF          8'h03
`define CCPC_B_SPREAD       8'h04
`define CCPC_B_DIS_STATE    8'h0B
`define CCPC_RST_OE         8'h0F
`define CCPC_RST_SLEW       8'h0F
`define CCPC_RST_AMP        8'hAA
`define CCPC_RST_ZERO       8'h00
// Byte 3 bit positions
`define CCPC_BIT_WOL        5
`define CCPC_BIT_REF_FOLLOW 4

// ============================================================
// Management bus target addresses and bit counts
`define CCPC_ADDR_LOW       7'h68
`define CCPC_ADDR_HIGH      7'h6A
`define CCPC_BITS_PER_BYTE  4'h8
`define CCPC_LAST_TX_BIT    4'h7

`endif

// ==== shared/ccpc_pkg.sv ====
// Purpose: Types of the clock output and power control block
// Assumes: Constants come from ccpc_defines.svh
// Notes:   Gray codes along the write path
`default_nettype none
package ccpc_pkg;

  // ============================================================
  // Spread strap levels and selections
  typedef enum logic [1:0] {
    CCPC_SPREAD_OFF     = 2'h0,
    CCPC_SPREAD_QUARTER = 2'h1,
    CCPC_SPREAD_HALF    = 2'h2
  } ccpc_spread_type;

  // Management bus slave states
  typedef enum logic [3:0] {
    CCPC_IDLE      = 4'h0,
    CCPC_ADDR      = 4'h1,
    CCPC_ACK_ADDR  = 4'h3,
    CCPC_CMD       = 4'h2,
    CCPC_ACK_CMD   = 4'h6,
    CCPC_WDATA     = 4'h7,
    CCPC_ACK_WDATA = 4'h5,
    CCPC_RDATA     = 4'h4,
    CCPC_ACK_RDATA = 4'hC
  } ccpc_bus_state_type;

  // Differential output group
  typedef struct packed {
    logic [3:0] diff_clock_true;
    logic [3:0] diff_clock_comp;
  } ccpc_pairs_type;

  // One two-way pin
  typedef struct packed {
    logic out;
    logic oe;
  } ccpc_pin_type;

endpackage

`default_nettype wire

// ==== rtl/ccpc_pair_gate.sv ====
// Purpose: Glitch-free gate of one differential pair
// Assumes: phase is the synchronised output clock level
// Notes:   Run state changes only while phase is low
`timescale 1ns/1ps
`default_nettype none

module ccpc_pair_gate
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       phase,
  input  wire logic       want_run,
  input  wire logic [1:0] dis_state,
  output logic            q_true,
  output logic            q_comp
);
  import ccpc_pkg::*;

  // State of the gate
  typedef struct packed {
    logic run;
    logic q_true;
    logic q_comp;
  } ccpc_gate_type;

  ccpc_gate_type st;       // Registered state
  ccpc_gate_type next_st;  // Next state

  // ============================================================
  // Next state
  always_comb
  begin
    next_st = st;
    // Switch only in the low half so no runt pulse is made
    if (!phase)
    begin
      next_st.run = want_run;
    end
    if (next_st.run)
    begin
      next_st.q_true = phase;
      next_st.q_comp = !phase;
    end
    else
    begin
      // Programmed static level of a stopped pair
      next_st.q_true = dis_state[0];
      next_st.q_comp = dis_state[1];
    end
  end

  // Register
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign q_true = st.q_true;
  assign q_comp = st.q_comp;

endmodule

`default_nettype wire

// ==== rtl/ccpc_core.sv ====
// Purpose: Output gating, straps, power modes and management bus of a 4-pair clock generator
// Assumes: PLL clock, lock, pins and bus lines are asynchronous and synchronised here
// Notes:   Reference output is modelled as a core clock divided by two
`timescale 1ns/1ps
`default_nettype none
`include "ccpc_defines.svh"

module ccpc_core
#(
  parameter int PAIRS = 4
)
(
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   power_down_n,
  input  wire logic [PAIRS-1:0]       pair_enable_n,
  input  wire logic [1:0]             spread_strap,
  input  wire logic                   pll_clock,
  input  wire logic                   pll_lock,
  input  wire logic                   address_strap,
  input  wire logic                   scl,
  input  wire logic                   sda_in,
  output ccpc_pkg::ccpc_pin_type      ref_pin,
  output ccpc_pkg::ccpc_pin_type      sda_pin,
  output ccpc_pkg::ccpc_pairs_type    pairs,
  output ccpc_pkg::ccpc_spread_type   spread_sel,
  output logic [7:0]                  slew_sel,
  output logic [7:0]                  amp_sel,
  output logic                        started
);
  import ccpc_pkg::*;

  // All state of the block apart from the pair gates
  typedef struct packed {
    logic [1:0]             pd_s;      // Power-down synchroniser
    logic [1:0]             lk_s;      // Lock synchroniser
    logic [1:0]             ph_s;      // PLL clock synchroniser
    logic [1:0]             ad_s;      // Address strap synchroniser
    logic [1:0][1:0]        sp_s;      // Spread strap synchroniser
    logic [1:0][PAIRS-1:0]  en_s;      // Enable pin synchroniser
    logic [1:0]             scl_s;     // Bus clock synchroniser
    logic [1:0]             sda_s;     // Bus data synchroniser
    logic                   scl_d;     // Bus clock, one cycle later
    logic                   sda_d;     // Bus data, one cycle later
    logic                   started;   // First power-up seen
    logic [6:0]             my_addr;   // Latched target address
    logic                   ref_tog;   // Reference divider
    ccpc_pin_type           ref_pin;   // Reference pin drive
    ccpc_pin_type           sda_pin;   // Bus data drive
    ccpc_bus_state_type     bst;       // Bus state
    logic [3:0]             cnt;       // Bit counter
    logic [7:0]             shift;     // Bus shift register
    logic                   rw;        // Read transfer
    logic                   mack;      // Host acknowledged a read byte
    logic [`CCPC_PTR_W-1:0] ptr;       // Configuration byte pointer
    logic [`CCPC_CFG_BYTES-1:0][7:0] cfg;  // Configuration bytes
  } ccpc_state_type;

  ccpc_state_type st;       // Registered state
  ccpc_state_type next_st;  // Next state
  logic [PAIRS-1:0] want_run;  // Pair run requests
  logic [PAIRS-1:0] q_true;    // Gate outputs, true
  logic [PAIRS-1:0] q_comp;    // Gate outputs, complement

  // ============================================================
  // Pair run condition
  always_comb
  begin
    for (int i = 0; i < PAIRS; i++)
    begin
      want_run[i] = st.started && st.pd_s[1]
                    && st.cfg[`CCPC_B_OE][i]
                    && !st.en_s[1][i]
                    && st.lk_s[1];
    end
  end

  // One gate per pair, fed by the synchronised PLL clock level
  genvar g;
  generate
    for (g = 0; g < PAIRS; g++)
    begin : gen_pair
      ccpc_pair_gate u_gate
      (
        .core_clk  (core_clk),
        .rst       (rst),
        .phase     (st.ph_s[1]),
        .want_run  (want_run[g]),
        .dis_state (st.cfg[`CCPC_B_DIS_STATE][1:0]),
        .q_true    (q_true[g]),
        .q_comp    (q_comp[g])
      );
    end
  endgenerate

  // ============================================================
  // Next state of straps, power, reference and bus
  always_comb
  begin
    logic start_c;  // Start condition
    logic stop_c;   // Stop condition
    logic rise;     // Bus clock rising
    logic fall;     // Bus clock falling
    start_c = 1'b0;
    stop_c  = 1'b0;
    rise    = 1'b0;
    fall    = 1'b0;
    next_st = st;
    // Synchronisers
    next_st.pd_s  = {st.pd_s[0], power_down_n};
    next_st.lk_s  = {st.lk_s[0], pll_lock};
    next_st.ph_s  = {st.ph_s[0], pll_clock};
    next_st.ad_s  = {st.ad_s[0], address_strap};
    next_st.sp_s  = {st.sp_s[0], spread_strap};
    next_st.en_s  = {st.en_s[0], pair_enable_n};
    next_st.scl_s = {st.scl_s[0], scl};
    next_st.sda_s = {st.sda_s[0], sda_in};
    next_st.scl_d = st.scl_s[1];
    next_st.sda_d = st.sda_s[1];

    // Straps caught once, on the first power-up high
    if (!st.started && st.pd_s[1])
    begin
      next_st.started = 1'b1;
      next_st.my_addr = st.ad_s[1] ? `CCPC_ADDR_HIGH : `CCPC_ADDR_LOW;
      next_st.cfg[`CCPC_B_SPREAD][1:0] = st.sp_s[1];
    end

    // Reference pin: floating, running or held low
    next_st.ref_tog = !st.ref_tog;
    if (!st.started)
    begin
      next_st.ref_pin = '0;
    end
    else if (!st.pd_s[1])
    begin
      // Power-down, unless wake-on-LAN keeps it running
      next_st.ref_pin.oe  = 1'b1;
      next_st.ref_pin.out = st.cfg[`CCPC_B_REF][`CCPC_BIT_WOL] && st.ref_tog;
    end
    else if (st.cfg[`CCPC_B_REF][`CCPC_BIT_REF_FOLLOW] && (st.cfg[`CCPC_B_OE][PAIRS-1:0] == '0))
    begin
      next_st.ref_pin = '{out: 1'b0, oe: 1'b1};
    end
    else
    begin
      next_st.ref_pin = '{out: st.ref_tog, oe: 1'b1};
    end

    // Bus line events
    rise    = st.scl_s[1] && !st.scl_d;
    fall    = !st.scl_s[1] && st.scl_d;
    start_c = st.scl_s[1] && st.scl_d && st.sda_d && !st.sda_s[1];
    stop_c  = st.scl_s[1] && st.scl_d && !st.sda_d && st.sda_s[1];

    if (!st.started)
    begin
      // Bus is silent until the address is known
      next_st.bst = CCPC_IDLE;
    end
    else if (start_c)
    begin
      next_st.bst     = CCPC_ADDR;
      next_st.cnt     = '0;
      next_st.sda_pin = '0;
    end
    else if (stop_c)
    begin
      next_st.bst     = CCPC_IDLE;
      next_st.sda_pin = '0;
    end
    else if (rise)
    begin
      // Sample data and host acknowledge
      case (st.bst)
        CCPC_ADDR, CCPC_CMD, CCPC_WDATA:
        begin
          next_st.shift = {st.shift[6:0], st.sda_s[1]};
          next_st.cnt   = st.cnt + 4'h1;
        end
        CCPC_ACK_RDATA:
        begin
          next_st.mack = !st.sda_s[1];
        end
        default:
        begin
          next_st.mack = st.mack;
        end
      endcase
    end
    else if (fall)
    begin
      // Drive acknowledges and read data in the low phase
      case (st.bst)
        CCPC_ADDR:
        begin
          if (st.cnt == `CCPC_BITS_PER_BYTE)
          begin
            if (st.shift[7:1] == st.my_addr)
            begin
              next_st.bst     = CCPC_ACK_ADDR;
              next_st.rw      = st.shift[0];
              next_st.sda_pin = '{out: 1'b0, oe: 1'b1};
            end
            else
            begin
              next_st.bst = CCPC_IDLE;
            end
          end
        end
        CCPC_ACK_ADDR:
        begin
          next_st.cnt = '0;
          if (st.rw)
          begin
            next_st.bst     = CCPC_RDATA;
            next_st.shift   = st.cfg[st.ptr];
            next_st.sda_pin = '{out: 1'b0, oe: !st.cfg[st.ptr][7]};
          end
          else
          begin
            next_st.bst     = CCPC_CMD;
            next_st.sda_pin = '0;
          end
        end
        CCPC_CMD, CCPC_WDATA:
        begin
          if (st.cnt == `CCPC_BITS_PER_BYTE)
          begin
            next_st.sda_pin = '{out: 1'b0, oe: 1'b1};
            if (st.bst == CCPC_CMD)
            begin
              next_st.ptr = st.shift;
              next_st.bst = CCPC_ACK_CMD;
            end
            else
            begin
              if (st.ptr < `CCPC_PTR_W'(`CCPC_CFG_BYTES))
              begin
                next_st.cfg[st.ptr] = st.shift;
              end
              next_st.bst = CCPC_ACK_WDATA;
            end
          end
        end
        CCPC_ACK_CMD, CCPC_ACK_WDATA:
        begin
          if (st.bst == CCPC_ACK_WDATA)
          begin
            next_st.ptr = st.ptr + `CCPC_PTR_W'(1);
          end
          next_st.bst     = CCPC_WDATA;
          next_st.cnt     = '0;
          next_st.sda_pin = '0;
        end
        CCPC_RDATA:
        begin
          next_st.cnt = st.cnt + 4'h1;
          if (st.cnt == `CCPC_LAST_TX_BIT)
          begin
            next_st.bst     = CCPC_ACK_RDATA;
            next_st.sda_pin = '0;
          end
          else
          begin
            next_st.shift   = {st.shift[6:0], 1'b0};
            next_st.sda_pin = '{out: 1'b0, oe: !st.shift[6]};
          end
        end
        CCPC_ACK_RDATA:
        begin
          if (st.mack)
          begin
            next_st.ptr     = st.ptr + `CCPC_PTR_W'(1);
            next_st.shift   = st.cfg[st.ptr + `CCPC_PTR_W'(1)];
            next_st.sda_pin = '{out: 1'b0, oe: !st.cfg[st.ptr + `CCPC_PTR_W'(1)][7]};
            next_st.cnt     = '0;
            next_st.bst     = CCPC_RDATA;
          end
          else
          begin
            next_st.bst = CCPC_IDLE;
          end
        end
        default:
        begin
          next_st.sda_pin = '0;
        end
      endcase
    end
  end

  // ============================================================
  // Register
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st                        <= '0;
      st.pd_s                   <= 2'h0;
      st.scl_s                  <= 2'h3;
      st.sda_s                  <= 2'h3;
      st.scl_d                  <= 1'b1;
      st.sda_d                  <= 1'b1;
      st.my_addr                <= `CCPC_ADDR_LOW;
      st.bst                    <= CCPC_IDLE;
      st.cfg[`CCPC_B_OE]        <= `CCPC_RST_OE;
      st.cfg[`CCPC_B_SLEW]      <= `CCPC_RST_SLEW;
      st.cfg[`CCPC_B_AMP]       <= `CCPC_RST_AMP;
      st.cfg[`CCPC_B_REF]       <= `CCPC_RST_ZERO;
      st.cfg[`CCPC_B_DIS_STATE] <= `CCPC_RST_ZERO;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs from flip-flops
  assign ref_pin    = st.ref_pin;
  assign sda_pin    = st.sda_pin;
  assign pairs      = '{diff_clock_true: q_true, diff_clock_comp: q_comp};
  assign spread_sel = ccpc_spread_type'(st.cfg[`CCPC_B_SPREAD][1:0]);
  assign slew_sel   = st.cfg[`CCPC_B_SLEW];
  assign amp_sel    = st.cfg[`CCPC_B_AMP];
  assign started    = st.started;

endmodule

`default_nettype wire

// ==== tb/ccpc_core_sva.sv ====
// Purpose: Port checks of the clock output block
// Assumes: One core_clk domain, rst synchronous
// Notes:   Bound to ccpc_core
`timescale 1ns/1ps
`default_nettype none

module ccpc_core_sva
#(
  parameter int PAIRS = 4
)
(
  input wire logic                     core_clk,
  input wire logic                     rst,
  input wire logic                     power_down_n,
  input wire logic                     pll_lock,
  input wire ccpc_pkg::ccpc_pin_type   ref_pin,
  input wire ccpc_pkg::ccpc_pin_type   sda_pin,
  input wire ccpc_pkg::ccpc_pairs_type pairs,
  input wire logic                     started
);
  import ccpc_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ============================================================
  // Cycles spent in power down, saturating
  logic [6:0] pd_low;
  always_ff @(posedge core_clk)
  begin
    if (rst || power_down_n)
      pd_low <= 7'h00;
    else if (pd_low != 7'h7F)
      pd_low <= pd_low + 7'h01;
  end
  // Lock absent long enough to pass the synchroniser
  sequence lock_gone;
    !pll_lock [*4];
  endsequence
  // Start seen and settled
  sequence start_done;
    started [*3];
  endsequence
  chk_reset_values: assert property ($past(rst) |-> pairs == 8'h00 && !ref_pin.oe && !started)
    else $error("outputs not cleared by reset");
  chk_lock_blocks: assert property (lock_gone |-> $stable(pairs))
    else $error("pairs moved without lock");
  chk_ref_float: assert property (!started |-> !ref_pin.oe)
    else $error("reference driven before start");
  chk_ref_after: assert property (start_done |-> ref_pin.oe)
    else $error("reference pin not driven after start");
  chk_start_held: assert property (started |=> started)
    else $error("start state lost");
  chk_start_cause: assert property ($rose(started) |-> $past(power_down_n, 1) && $past(power_down_n, 2))
    else $error("start without power up level");
  chk_bus_quiet: assert property (!started |-> !sda_pin.oe)
    else $error("bus driven before start");
  chk_sda_low: assert property (sda_pin.oe |-> !sda_pin.out)
    else $error("data line driven high");
  chk_pd_static: assert property (pd_low >= 7'h40 |-> $stable(pairs))
    else $error("pairs move in power down");
endmodule

bind ccpc_core ccpc_core_sva #(.PAIRS(PAIRS)) u_sva (.core_clk, .rst, .power_down_n, .pll_lock,
  .ref_pin, .sda_pin, .pairs, .started);

`default_nettype wire

// ==== tb/ccpc_smbus_host.sv ====
// Purpose: Management bus host model
// Assumes: 800 ns bus clock period from core_clk
// Notes:   Line has a pull-up
`timescale 1ns/1ps
`default_nettype none

module ccpc_smbus_host
(
  input  wire logic core_clk,
  input  wire logic dut_pull,
  output logic      scl,
  output logic      sda
);
  logic host_pull; // Host holds data low
  // Wired-AND line, pulled up when released
  assign sda = !(host_pull || dut_pull);
  initial
  begin
    scl = 1'b1;
    host_pull = 1'b0;
  end
  // Quarter of a bus clock period
  task automatic q;
    repeat (2) @(posedge core_clk);
  endtask
  // One bit, MSB-first caller; samples while clock is high
  task automatic xbit(input logic b, output logic r);
    host_pull <= !b;
    q();
    scl <= 1'b1;
    q();
    r = sda;
    q();
    scl <= 1'b0;
    q();
  endtask
  // Start or repeated start
  task automatic start;
    host_pull <= 1'b0;
    q();
    q();
    scl <= 1'b1;
    q();
    host_pull <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic stop;
    host_pull <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    host_pull <= 1'b0;
    q();
  endtask
  // Byte plus ninth bit m; ack is the ninth bit seen low
  task automatic xbyte(input logic [7:0] d, input logic m, output logic [7:0] r, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      xbit(d[i], b);
      r[i] = b;
    end
    xbit(m, b);
    ack = !b;
  endtask
  // Byte write: address, pointer, data
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic       k0, k1, k2;
    start();
    xbyte({a, 1'b0}, 1'b1, r, k0);
    xbyte(p, 1'b1, r, k1);
    xbyte(d, 1'b1, r, k2);
    stop();
    ok = k0 && k1 && k2;
  endtask
  // Byte read with repeated start, host ends with no-ack
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic       k0, k1, k2;
    start();
    xbyte({a, 1'b0}, 1'b1, r, k0);
    xbyte(p, 1'b1, r, k1);
    start();
    xbyte({a, 1'b1}, 1'b1, r, k2);
    xbyte(8'hFF, 1'b1, d, r[0]);
    stop();
    ok = k0 && k1 && k2;
  endtask
endmodule

`default_nettype wire

// ==== tb/test_clock_output_power_control.sv ====
// Purpose: Self-checking bench of the clock output block
// Assumes: 10 MHz core clock, PLL level toggles every 8 cycles
// Notes:   Straps, gating, power modes and bus
`timescale 1ns/1ps
`default_nettype none
`include "ccpc_defines.svh"

module test_clock_output_power_control;
  import ccpc_pkg::*;
  logic            core_clk, rst, power_down_n, pll_lock, strap, scl, sda, started, ok;
  logic [3:0]      pair_enable_n, pll_div;
  logic [1:0]      spread_strap;
  logic [7:0]      slew_sel, amp_sel, d, act;
  logic            address_strap, pll_clock;
  ccpc_pin_type    ref_pin, sda_pin;
  ccpc_pairs_type  pairs;
  ccpc_spread_type spread_sel;
  int              miscompares, cmp_count;
  // Shared pin: reference drive wins, else strap with pull-down
  assign address_strap = ref_pin.oe ? ref_pin.out : strap;
  assign pll_clock = pll_div[3];
  always #50 core_clk = !core_clk;
  // Slow PLL level for the core to sample
  always @(posedge core_clk)
    pll_div <= pll_div + 4'h1;
  ccpc_core dut (.core_clk(core_clk), .rst(rst), .power_down_n(power_down_n),
    .pair_enable_n(pair_enable_n), .spread_strap(spread_strap), .pll_clock(pll_clock),
    .pll_lock(pll_lock), .address_strap(address_strap), .scl(scl), .sda_in(sda),
    .ref_pin(ref_pin), .sda_pin(sda_pin), .pairs(pairs), .spread_sel(spread_sel),
    .slew_sel(slew_sel), .amp_sel(amp_sel), .started(started));
  ccpc_smbus_host host (.core_clk(core_clk), .dut_pull(sda_pin.oe), .scl(scl), .sda(sda));
  // ============================================================
  // Checks and helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Bit k set when pair k (bit 4: reference) toggles
  task automatic watch(output logic [7:0] a);
    logic [4:0] prev, cur;
    int         n [5];
    a = 8'h00;
    prev = {ref_pin.out, pairs.diff_clock_true};
    for (int k = 0; k < 5; k++)
      n[k] = 0;
    repeat (64)
    begin
      cyc(1);
      cur = {ref_pin.out, pairs.diff_clock_true};
      for (int k = 0; k < 5; k++)
        n[k] += (cur[k] !== prev[k]);
      prev = cur;
    end
    for (int k = 0; k < 5; k++)
      a[k] = n[k] > 2;
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ============================================================
  // Main sequence
  initial
  begin
    {core_clk, rst, power_down_n, pll_lock, strap, pll_div} = 9'h080;
    pair_enable_n = 4'hF;
    spread_strap = 2'h0;
    miscompares = 0;
    cmp_count = 0;
    cyc(20);
    rst <= 1'b0;
    cyc(2);
    chk(pairs, 8'h00);
    chk({4'h0, started, ref_pin.oe, spread_sel}, 8'h00);
    chk(slew_sel, `CCPC_RST_SLEW);
    chk(amp_sel, `CCPC_RST_AMP);
    host.wr(`CCPC_ADDR_HIGH, `CCPC_B_SLEW, 8'h5A, ok);
    chk({7'h00, ok}, 8'h00);
    // Straps latched on first power up
    spread_strap <= 2'h1;
    strap <= 1'b1;
    power_down_n <= 1'b1;
    cyc(8);
    strap <= 1'b0;
    chk({4'h0, started, ref_pin.oe, spread_sel}, {4'h0, 2'b11, CCPC_SPREAD_QUARTER});
    pair_enable_n <= 4'h0;
    watch(act);
    chk(act, 8'h10);
    pll_lock <= 1'b1;
    cyc(8);
    watch(act);
    chk(act, 8'h1F);
    pair_enable_n <= 4'h5;
    cyc(64);
    watch(act);
    chk(act, 8'h1A);
    host.wr(`CCPC_ADDR_HIGH, `CCPC_B_DIS_STATE, 8'h01, ok);
    chk({7'h00, ok}, 8'h01);
    chk({6'h00, pairs.diff_clock_true[0], pairs.diff_clock_comp[0]}, 8'h02);
    host.wr(`CCPC_ADDR_LOW, `CCPC_B_SLEW, 8'h33, ok);
    chk({7'h00, ok}, 8'h00);
    host.wr(`CCPC_ADDR_HIGH, `CCPC_B_SLEW, 8'h5A, ok);
    host.wr(`CCPC_ADDR_HIGH, `CCPC_B_SPREAD, 8'h02, ok);
    cyc(4);
    chk(slew_sel, 8'h5A);
    chk({6'h00, spread_sel}, {6'h00, CCPC_SPREAD_HALF});
    host.rd(`CCPC_ADDR_HIGH, `CCPC_B_AMP, d, ok);
    chk(d, `CCPC_RST_AMP);
    chk({7'h00, ok}, 8'h01);
    // Bus enable bits and reference following them
    pair_enable_n <= 4'h0;
    host.wr(`CCPC_ADDR_HIGH, `CCPC_B_OE, 8'h0E, ok);
    cyc(64);
    watch(act);
    chk(act, 8'h1E);
    host.wr(`CCPC_ADDR_HIGH, `CCPC_B_REF, 8'h01 << `CCPC_BIT_REF_FOLLOW, ok);
    host.wr(`CCPC_ADDR_HIGH, `CCPC_B_OE, 8'h00, ok);
    cyc(64);
    watch(act);
    chk(act, 8'h00);
    chk({6'h00, ref_pin.oe, ref_pin.out}, 8'h02);
    host.wr(`CCPC_ADDR_HIGH, `CCPC_B_OE, `CCPC_RST_OE, ok);
    // Power down, then wake-on-LAN
    spread_strap <= 2'h0;
    power_down_n <= 1'b0;
    cyc(80);
    watch(act);
    chk(act, 8'h00);
    chk({6'h00, ref_pin.oe, ref_pin.out}, 8'h02);
    host.wr(`CCPC_ADDR_HIGH, `CCPC_B_REF, 8'h01 << `CCPC_BIT_WOL, ok);
    watch(act);
    chk(act, 8'h10);
    power_down_n <= 1'b1;
    cyc(80);
    watch(act);
    chk(act, 8'h1F);
    chk({6'h00, spread_sel}, {6'h00, CCPC_SPREAD_HALF});
    host.rd(`CCPC_ADDR_HIGH, `CCPC_B_SLEW, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, 8'h5A);
    wrap_up();
  end
  // Watchdog on the whole run
  initial
  begin
    #3000000;
    miscompares++;
    wrap_up();
  end
endmodule

`default_nettype wire
